/* hdl/cce_compare_unit.sv */
// compare event unit: two 16-bit compare channels against timer one,
// timer-two time base, flag/enable registers, apb slave.
// assumes an apb master on clk and synchronous count_input/adc_enabled.
//
// Operation
// - compare value continuously matched against timer one
// - match drives output high, low, or unchanged
// - match sets the unit event flag
// - zero control write forces latch low
// - software-interrupt mode: pin untouched, flag set
// - unit one special event resets timer one
// - unit two special event also starts conversion
// - special event reset never sets overflow flag
// - timer-two prescaler divides by 1, 4, 16
// - timer one kept through reset, trigger clears
//
// Implementation choice: the APB interface to the registers.
`default_nettype none
module cce_compare_unit (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire cce_pkg::cce_apb_req_s apb_req,
   output var cce_pkg::cce_apb_rsp_s apb_rsp,
   input wire logic count_input,
   input wire logic adc_enabled,
   output logic [1:0] compare_out,
   output logic adc_start,
   output logic periph_irq
);
   import cce_pkg::*;

   logic [1:0] rst_pipe;
   logic rst_sync_b;
   cce_state_s s_reg;
   cce_state_s s_next;
   logic [15:0] t1_count;
   logic t1_tick;
   logic t2_tick;
   logic [7:0] idx;
   logic sel_ok;
   logic bus_done;
   logic bus_wr;
   logic [7:0] wbyte;
   logic [1:0] cmp_mode;
   logic [1:0] hit_eq;
   logic [1:0] evt;
   logic [1:0] special;
   logic t1_clear;
   logic t1_wr_lo;
   logic t1_wr_hi;
   logic t1_run;
   logic t1_ovf;
   logic t2_pre_clr;
   logic [3:0] t1_mask;
   logic [3:0] t2_mask;
   logic [7:0] rd_byte;
   logic rd_hit;

   // reset release through two flops; assertion is still asynchronous
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_sync_b = rst_pipe[1];

   // bus decode; a transfer completes while our registered pready is high
   assign idx = apb_req.paddr[IDX_MSB:IDX_LSB];
   assign sel_ok = (apb_req.paddr[ADDR_W-1:IDX_MSB+1] == 2'h0) &&
                   (apb_req.paddr[IDX_LSB-1:0] == 2'h0);
   assign bus_done = apb_req.psel && apb_req.penable && s_reg.rsp.pready;
   assign bus_wr = bus_done && apb_req.pwrite && sel_ok;
   assign wbyte = apb_req.pwdata[7:0];

   // per-channel match detection, edge-qualified so it fires once
   for (genvar u = 0; u < 2; u++) begin : g_unit
      assign cmp_mode[u] =
         s_reg.unit_ctl[u][MODE_MSB:MODE_MSB-1] == MODE_CMP_TOP;
      assign hit_eq[u] = cmp_mode[u] &&
         (t1_count == s_reg.cmp_val[u]);
      assign evt[u] = hit_eq[u] && !s_reg.prev_match[u];
      assign special[u] = evt[u] &&
         (s_reg.unit_ctl[u][MODE_MSB:MODE_LSB] == MODE_SPECIAL);
   end

   // timer-one controls; either trigger clears the pair
   assign t1_clear = |special;
   assign t1_wr_lo = bus_wr && (idx == IDX_T1_LO);
   assign t1_wr_hi = bus_wr && (idx == IDX_T1_HI);
   assign t1_run = s_reg.t1_ctl[T1_ON] && (s_reg.t1_ctl[T1_SRC] ?
                   (count_input && !s_reg.ext_prev) : 1'b1);
   // a trigger-caused clear is not a rollover, so no overflow flag
   assign t1_ovf = t1_tick && (t1_count == T1_FULL) && !t1_clear &&
                   !t1_wr_lo && !t1_wr_hi;
   assign t2_pre_clr = bus_wr && ((idx == IDX_T2_CNT) ||
                                  (idx == IDX_T2_CTL));

   // prescale ratio selection
   always_comb begin
      case (s_reg.t1_ctl[T1_PS_MSB:T1_PS_LSB])
         2'h0: t1_mask = PS_DIV1;
         2'h1: t1_mask = PS_DIV2;
         2'h2: t1_mask = PS_DIV4;
         default: t1_mask = PS_DIV8;
      endcase
      case (s_reg.t2_ctl[T2_PS_MSB:T2_PS_LSB])
         2'h0: t2_mask = PS_DIV1;
         2'h1: t2_mask = PS_DIV4;
         default: t2_mask = PS_DIV16;
      endcase
   end

   cce_prescaler u_t1_pre (
      .clk(clk),
      .rst_b(rst_sync_b),
      .ce(ce),
      .run(t1_run),
      .clear(t1_wr_lo || t1_wr_hi),
      .mask(t1_mask),
      .tick(t1_tick)
   );

   cce_prescaler u_t2_pre (
      .clk(clk),
      .rst_b(rst_sync_b),
      .ce(ce),
      .run(s_reg.t2_ctl[T2_ON]),
      .clear(t2_pre_clr),
      .mask(t2_mask),
      .tick(t2_tick)
   );

   cce_timer_one u_t1 (
      .clk(clk),
      .ce(ce),
      .clear(t1_clear),
      .wr_lo(t1_wr_lo),
      .wr_hi(t1_wr_hi),
      .wbyte(wbyte),
      .inc(t1_tick),
      .count(t1_count)
   );

   // read mux; unknown indices answer with pslverr
   always_comb begin
      rd_hit = 1'b1;
      rd_byte = 8'h00;
      case (idx)
         IDX_INT_CTL: rd_byte = s_reg.int_ctl;
         IDX_FLAGS1: rd_byte = s_reg.flags1;
         IDX_FLAGS2: rd_byte = {7'h00, s_reg.flags2};
         IDX_T1_LO: rd_byte = t1_count[7:0];
         IDX_T1_HI: rd_byte = t1_count[15:8];
         IDX_T1_CTL: rd_byte = {2'h0, s_reg.t1_ctl};
         IDX_T2_CNT: rd_byte = s_reg.t2_cnt;
         IDX_T2_CTL: rd_byte = {5'h00, s_reg.t2_ctl};
         IDX_T2_PER: rd_byte = s_reg.t2_per;
         IDX_CV1_LO: rd_byte = s_reg.cmp_val[0][7:0];
         IDX_CV1_HI: rd_byte = s_reg.cmp_val[0][15:8];
         IDX_U1_CTL: rd_byte = {2'h0, s_reg.unit_ctl[0]};
         IDX_CV2_LO: rd_byte = s_reg.cmp_val[1][7:0];
         IDX_CV2_HI: rd_byte = s_reg.cmp_val[1][15:8];
         IDX_U2_CTL: rd_byte = {2'h0, s_reg.unit_ctl[1]};
         IDX_EN1: rd_byte = s_reg.en1;
         IDX_EN2: rd_byte = {7'h00, s_reg.en2};
         default: rd_hit = 1'b0;
      endcase
   end

   // next-state: bus, software writes, then hardware events on top so
   // that a flag set in the same cycle as its clear is never lost
   always_comb begin
      s_next = s_reg;
      s_next.rsp.pready = apb_req.psel && apb_req.penable &&
                          !s_reg.rsp.pready;
      s_next.rsp.pslverr = s_next.rsp.pready && !(rd_hit && sel_ok);
      if (s_next.rsp.pready) begin
         s_next.rsp.prdata = {24'h000000, rd_byte};
      end
      if (bus_wr) begin
         case (idx)
            IDX_INT_CTL: s_next.int_ctl = wbyte;
            IDX_FLAGS1: s_next.flags1 = wbyte;
            IDX_FLAGS2: s_next.flags2 = wbyte[0];
            IDX_T1_CTL: s_next.t1_ctl = wbyte[5:0];
            IDX_T2_CNT: s_next.t2_cnt = wbyte;
            IDX_T2_CTL: s_next.t2_ctl = wbyte[2:0];
            IDX_T2_PER: s_next.t2_per = wbyte;
            IDX_CV1_LO: s_next.cmp_val[0][7:0] = wbyte;
            IDX_CV1_HI: s_next.cmp_val[0][15:8] = wbyte;
            IDX_CV2_LO: s_next.cmp_val[1][7:0] = wbyte;
            IDX_CV2_HI: s_next.cmp_val[1][15:8] = wbyte;
            IDX_U1_CTL: s_next.unit_ctl[0] = wbyte[5:0];
            IDX_U2_CTL: s_next.unit_ctl[1] = wbyte[5:0];
            IDX_EN1: s_next.en1 = wbyte;
            IDX_EN2: s_next.en2 = wbyte[0];
            default: ;
         endcase
      end
      s_next.ext_prev = count_input;
      // timer two: counts to the period, then restarts and flags
      if (t2_tick) begin
         if (s_reg.t2_cnt == s_reg.t2_per) begin
            s_next.t2_cnt = 8'h00;
            s_next.flags1[FLG_T2_MATCH] = 1'b1;
         end else begin
            s_next.t2_cnt = s_reg.t2_cnt + 8'h01;
         end
      end
      if (t1_ovf) begin
         s_next.flags1[FLG_T1_OVF] = 1'b1;
      end
      // compare actions use the mode that stood before any write
      for (int u = 0; u < 2; u++) begin
         s_next.prev_match[u] = hit_eq[u];
         if (evt[u]) begin
            case (s_reg.unit_ctl[u][MODE_MSB:MODE_LSB])
               MODE_SET_HIGH: s_next.out_latch[u] = 1'b1;
               MODE_SET_LOW: s_next.out_latch[u] = 1'b0;
               default: ;
            endcase
         end
      end
      // a zero control write beats a match action of the same cycle,
      // so software can always park the latch low
      if (bus_wr && (wbyte == CTL_CLEAR)) begin
         if (idx == IDX_U1_CTL) begin
            s_next.out_latch[0] = 1'b0;
         end
         if (idx == IDX_U2_CTL) begin
            s_next.out_latch[1] = 1'b0;
         end
      end
      if (evt[0]) begin
         s_next.flags1[FLG_U1_EVT] = 1'b1;
      end
      if (evt[1]) begin
         s_next.flags2 = 1'b1;
      end
      s_next.ad_start = special[1] && adc_enabled;
      s_next.irq = s_reg.int_ctl[INT_GLOBAL] &&
                   s_reg.int_ctl[INT_PERIPH] &&
                   ((|(s_reg.flags1 & s_reg.en1)) ||
                    (s_reg.flags2 && s_reg.en2));
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         s_reg <= STATE_RST;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign apb_rsp = s_reg.rsp;
   assign compare_out = s_reg.out_latch;
   assign adc_start = s_reg.ad_start;
   assign periph_irq = s_reg.irq;

   // checks on match handling and triggers
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_sync_b);

   match_flag_a: assert property (
      ce && cmp_mode[0] && (t1_count == s_reg.cmp_val[0]) &&
      !s_reg.prev_match[0] |-> ##1 s_reg.flags1[FLG_U1_EVT])
      else $error("unit one match did not raise its flag");

   flag_two_a: assert property (
      ce && evt[1] |=> s_reg.flags2)
      else $error("unit two event flag missing after match");

   drive_high_a: assert property (
      ce && evt[0] && s_reg.unit_ctl[0][MODE_MSB:MODE_LSB] == MODE_SET_HIGH
      |=> compare_out[0])
      else $error("compare output not driven high");

   drive_low_a: assert property (
      ce && evt[1] && s_reg.unit_ctl[1][MODE_MSB:MODE_LSB] == MODE_SET_LOW
      && !(bus_wr && idx == IDX_U2_CTL) |=> !compare_out[1])
      else $error("compare output not driven low");

   soft_pin_a: assert property (
      ce && evt[0] && s_reg.unit_ctl[0][MODE_MSB:MODE_LSB] == MODE_SOFT_INT
      && !(bus_wr && idx == IDX_U1_CTL) |=> $stable(compare_out[0]))
      else $error("pin moved in software interrupt mode");

   ctl_clear_a: assert property (
      ce && bus_wr && idx == IDX_U1_CTL && wbyte == CTL_CLEAR
      |=> !compare_out[0] && s_reg.unit_ctl[0] == 6'h00)
      else $error("clearing control left the latch set");

   trig_reset_a: assert property (
      ce && special[0] |=> t1_count == 16'h0000 ##1
      (t1_count == 16'h0000 || t1_count == 16'h0001))
      else $error("special event did not reset timer one");

   adc_kick_a: assert property (
      ce && special[1] && adc_enabled |=> adc_start ##1 !adc_start)
      else $error("conversion start missing or not a pulse");

   no_ovf_a: assert property (
      ce && t1_clear && !s_reg.flags1[FLG_T1_OVF]
      |=> !s_reg.flags1[FLG_T1_OVF])
      else $error("trigger reset raised the overflow flag");

   once_only_a: assert property (
      ce && evt[0] ##1 ce && hit_eq[0] |-> !evt[0])
      else $error("match fired again while count stayed equal");

   bus_answer_a: assert property (
      apb_req.psel && apb_req.penable && !apb_rsp.pready && ce
      |=> apb_rsp.pready)
      else $error("apb access not answered in one wait cycle");

   cov_high_c: cover property (evt[0] ##1 compare_out[0]);
   cov_special_c: cover property (special[0] ##1 t1_count == 16'h0000);
   cov_adc_c: cover property (adc_start);
   cov_t2_c: cover property (t2_tick && s_reg.t2_ctl[T2_PS_MSB]);
endmodule
`default_nettype wire

/* hdl/cce_pkg.sv */
// package for the compare event unit: register indices, field positions,
// reset values, mode codes and the structs that carry bus and state.
// assumes an apb master with 32-bit data and word-aligned registers.
`default_nettype none
package cce_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 9;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_INT_CTL = 8'h0B;
   localparam logic [7:0] IDX_FLAGS1 = 8'h0C;
   localparam logic [7:0] IDX_FLAGS2 = 8'h0D;
   localparam logic [7:0] IDX_T1_LO = 8'h0E;
   localparam logic [7:0] IDX_T1_HI = 8'h0F;
   localparam logic [7:0] IDX_T1_CTL = 8'h10;
   localparam logic [7:0] IDX_T2_CNT = 8'h11;
   localparam logic [7:0] IDX_T2_CTL = 8'h12;
   localparam logic [7:0] IDX_CV1_LO = 8'h15;
   localparam logic [7:0] IDX_CV1_HI = 8'h16;
   localparam logic [7:0] IDX_U1_CTL = 8'h17;
   localparam logic [7:0] IDX_CV2_LO = 8'h1B;
   localparam logic [7:0] IDX_CV2_HI = 8'h1C;
   localparam logic [7:0] IDX_U2_CTL = 8'h1D;
   localparam logic [7:0] IDX_EN1 = 8'h8C;
   localparam logic [7:0] IDX_EN2 = 8'h8D;
   localparam logic [7:0] IDX_T2_PER = 8'h92;
   // field positions
   localparam int FLG_T1_OVF = 0;
   localparam int FLG_T2_MATCH = 1;
   localparam int FLG_U1_EVT = 2;
   localparam int INT_GLOBAL = 7;
   localparam int INT_PERIPH = 6;
   localparam int T1_ON = 0;
   localparam int T1_SRC = 1;
   localparam int T1_PS_LSB = 4;
   localparam int T1_PS_MSB = 5;
   localparam int T2_ON = 2;
   localparam int T2_PS_LSB = 0;
   localparam int T2_PS_MSB = 1;
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 3;
   // compare modes of the unit control low nibble
   localparam logic [1:0] MODE_CMP_TOP = 2'h2;
   localparam logic [3:0] MODE_SET_HIGH = 4'h8;
   localparam logic [3:0] MODE_SET_LOW = 4'h9;
   localparam logic [3:0] MODE_SOFT_INT = 4'hA;
   localparam logic [3:0] MODE_SPECIAL = 4'hB;
   // prescaler masks, ratio is mask plus one
   localparam logic [3:0] PS_DIV1 = 4'h0;
   localparam logic [3:0] PS_DIV2 = 4'h1;
   localparam logic [3:0] PS_DIV4 = 4'h3;
   localparam logic [3:0] PS_DIV8 = 4'h7;
   localparam logic [3:0] PS_DIV16 = 4'hF;
   localparam logic [15:0] T1_FULL = 16'hFFFF;
   localparam logic [15:0] T1_POWERUP = 16'h0000;
   localparam logic [7:0] T2_PER_RST = 8'hFF;
   localparam logic [7:0] CTL_CLEAR = 8'h00;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } cce_apb_req_s;

   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } cce_apb_rsp_s;

   typedef struct packed {
      cce_apb_rsp_s rsp;
      logic [7:0] int_ctl;
      logic [7:0] flags1;
      logic [7:0] en1;
      logic flags2;
      logic en2;
      logic [5:0] t1_ctl;
      logic [1:0][15:0] cmp_val;
      logic [1:0][5:0] unit_ctl;
      logic [7:0] t2_cnt;
      logic [7:0] t2_per;
      logic [2:0] t2_ctl;
      logic [1:0] out_latch;
      logic [1:0] prev_match;
      logic ext_prev;
      logic ad_start;
      logic irq;
   } cce_state_s;

   typedef struct packed {
      logic [15:0] count;
   } cce_tmr_s;

   typedef struct packed {
      logic [3:0] cnt;
      logic tick;
   } cce_pre_s;

   localparam cce_state_s STATE_RST = '{default: '0, t2_per: T2_PER_RST};
endpackage
`default_nettype wire

/* hdl/cce_prescaler.sv */
// clock prescaler: one-cycle tick every (mask + 1) enabled cycles.
// assumes the caller's reset is already synchronous to clk.
`default_nettype none
module cce_prescaler (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic run,
   input wire logic clear,
   input wire logic [3:0] mask,
   output logic tick
);
   import cce_pkg::*;
   cce_pre_s p_reg;
   cce_pre_s p_next;

   // a clear restarts the ratio so a timer write begins a full period
   always_comb begin
      p_next = p_reg;
      p_next.tick = run && !clear && ((p_reg.cnt & mask) == mask);
      if (clear) begin
         p_next.cnt = 4'h0;
      end else if (run) begin
         p_next.cnt = p_reg.cnt + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         p_reg <= '0;
      end else if (ce) begin
         p_reg <= p_next;
      end
   end

   assign tick = p_reg.tick;
endmodule
`default_nettype wire

/* hdl/cce_timer_one.sv */
// 16-bit timer-one count pair, deliberately without any reset input.
// assumes clear, byte writes and increment are one-cycle pulses.
`default_nettype none
module cce_timer_one (
   input wire logic clk,
   input wire logic ce,
   input wire logic clear,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [7:0] wbyte,
   input wire logic inc,
   output logic [15:0] count
);
   import cce_pkg::*;
   // power-up content is arbitrary in silicon; zero keeps simulation clean
   cce_tmr_s t_reg = '{count: T1_POWERUP};
   cce_tmr_s t_next;

   // trigger clear beats a software write, a write beats the increment
   always_comb begin
      t_next = t_reg;
      if (clear) begin
         t_next.count = '0;
      end else if (wr_lo) begin
         t_next.count = {t_reg.count[15:8], wbyte};
      end else if (wr_hi) begin
         t_next.count = {wbyte, t_reg.count[7:0]};
      end else if (inc) begin
         t_next.count = t_reg.count + 16'h0001;
      end
   end

   // no reset on purpose: the count survives every reset
   always_ff @(posedge clk) begin
      if (ce) begin
         t_reg <= t_next;
      end
   end

   assign count = t_reg.count;
endmodule
`default_nettype wire

/* tb/cce_far_side.sv */
// far-side model: count pulses for timer one, the converter enable,
// and a tally of conversion start pulses seen from the unit.
// assumes every input comes from the bench clock domain.
`default_nettype none
module cce_far_side (
   input wire logic clk,
   input wire logic pulse_on,
   input wire logic conv_on,
   input wire logic tally_clr,
   input wire logic adc_start,
   output logic count_input,
   output logic adc_enabled,
   output int n_start
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div;
   initial begin
      div = 2'h0;
      n_start = 0;
   end
   // pulses come from the same clock, as a synchronised counter needs
   always @(posedge clk) begin
      div <= div + 2'h1;
      if (tally_clr)
         n_start <= 0;
      else if (adc_start === 1'b1)
         n_start <= n_start + 1;
   end
   // one rising edge every four cycles, none while idle
   assign count_input = pulse_on & div[1];
   assign adc_enabled = conv_on;
endmodule
`default_nettype wire

/* tb/ccp_compare_event_unit_bench.sv */
// bench for the compare event unit: apb read/write tasks and a sequence
// of register-level tests with expected values.
// assumes the design files of hdl/ and the far-side model are compiled.
`default_nettype none
module ccp_compare_event_unit_bench;
   import cce_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b;
   logic ce = 1'b1;
   cce_apb_req_s req;
   cce_apb_rsp_s rsp;
   logic [1:0] compare_out;
   logic adc_start, periph_irq, count_input, adc_enabled;
   logic pulse_on, conv_on, tally_clr;
   logic [7:0] rd;
   logic err;
   int n_start, n;
   int n_mismatch = 0;
   int checked = 0;
   int cyc = 0;

   // 40 MHz clock
   always #12.5 clk = ~clk;

   cce_compare_unit u_cce_compare_unit (
      .clk(clk), .rst_b(rst_b), .ce(ce), .apb_req(req), .apb_rsp(rsp),
      .count_input(count_input), .adc_enabled(adc_enabled),
      .compare_out(compare_out), .adc_start(adc_start),
      .periph_irq(periph_irq));

   // the pin is only observed, as an output all run
   cce_far_side u_cce_far_side (
      .clk(clk), .pulse_on(pulse_on), .conv_on(conv_on),
      .tally_clr(tally_clr), .adc_start(adc_start),
      .count_input(count_input), .adc_enabled(adc_enabled),
      .n_start(n_start));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // a hang ends in the same report
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; entered right after a rising edge
   task automatic xfer(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= {2'h0, idx, 2'h0};
      req.pwdata <= {24'h0, wd};
      @(posedge clk);
      req.penable <= 1'b1;
      // only the bench timeout ends a wait for pready
      do begin
         @(posedge clk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata[7:0];
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      // one idle edge so no strobe is assigned twice in a time step
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp,
                      input string what);
      xfer(1'b0, idx, 8'h00);
      chk(what, {8'h00, exp}, {8'h00, rd});
   endtask

   // bounded wait for latch bit of unit one (pick 0) or the irq (pick 1)
   task automatic wait_sig(input bit pick, input logic lvl, output int t);
      logic s;
      t = 0;
      s = pick ? periph_irq : compare_out[0];
      while (s !== lvl && t < 400) begin
         @(posedge clk);
         t++;
         s = pick ? periph_irq : compare_out[0];
      end
      chk("wait for level", {15'h0, lvl}, {15'h0, s});
   endtask

   initial begin
      req = '0;
      rst_b = 1'b0;
      pulse_on = 1'b0;
      conv_on = 1'b0;
      tally_clr = 1'b0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      // reset values and a hole in the map
      rdc(IDX_U1_CTL, CTL_CLEAR, "unit one control");
      rdc(IDX_T1_CTL, 8'h00, "timer one control");
      rdc(IDX_FLAGS1, 8'h00, "flags one");
      rdc(IDX_T2_PER, T2_PER_RST, "timer two period");
      xfer(1'b0, 8'h50, 8'h00);
      chk("unmapped error", 16'h0001, {15'h0, err});
      // timer one survives a reset in mid-run
      wr(IDX_T1_LO, 8'h34);
      wr(IDX_T1_HI, 8'h12);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      rdc(IDX_T1_LO, 8'h34, "timer low kept");
      rdc(IDX_T1_HI, 8'h12, "timer high kept");
      // drive high on match, then low, then high again
      wr(IDX_CV1_LO, 8'h30);
      wr(IDX_CV1_HI, 8'h00);
      wr(IDX_U1_CTL, {4'h0, MODE_SET_HIGH});
      wr(IDX_T1_LO, 8'h00);
      wr(IDX_T1_HI, 8'h00);
      wr(IDX_T1_CTL, 8'h01);
      wait_sig(1'b0, 1'b1, n);
      chk("match time", 16'h0001, {15'h0, n > 43 && n < 53});
      rdc(IDX_FLAGS1, 8'h04, "unit one flag");
      wr(IDX_U1_CTL, {4'h0, MODE_SET_LOW});
      chk("latch kept", 16'h0001, {15'h0, compare_out[0]});
      wr(IDX_T1_LO, 8'h00);
      wait_sig(1'b0, 1'b0, n);
      wr(IDX_U1_CTL, {4'h0, MODE_SET_HIGH});
      wr(IDX_T1_LO, 8'h00);
      wait_sig(1'b0, 1'b1, n);
      // clock enable low freezes the count: two reads still 4 apart
      xfer(1'b0, IDX_T1_LO, 8'h00);
      n = rd;
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      xfer(1'b0, IDX_T1_LO, 8'h00);
      chk("frozen count", 16'h0004, {8'h00, 8'(rd - n[7:0])});
      // flag-only mode: irq rises, pin stays
      wr(IDX_INT_CTL, 8'hC0);
      wr(IDX_EN1, 8'h04);
      wr(IDX_FLAGS1, 8'h00);
      wr(IDX_U1_CTL, {4'h0, MODE_SOFT_INT});
      wr(IDX_T1_LO, 8'h00);
      wait_sig(1'b1, 1'b1, n);
      chk("pin untouched", 16'h0001, {15'h0, compare_out[0]});
      wr(IDX_U1_CTL, CTL_CLEAR);
      chk("latch cleared", 16'h0000, {15'h0, compare_out[0]});
      // stopped timer held equal: one event only
      wr(IDX_T1_CTL, 8'h00);
      wr(IDX_U1_CTL, {4'h0, MODE_SOFT_INT});
      wr(IDX_FLAGS1, 8'h00);
      wr(IDX_T1_HI, 8'h00);
      wr(IDX_T1_LO, 8'h30);
      rdc(IDX_FLAGS1, 8'h04, "event on equality");
      wr(IDX_FLAGS1, 8'h00);
      repeat (20) @(posedge clk);
      rdc(IDX_FLAGS1, 8'h00, "no second event");
      chk("irq low", 16'h0000, {15'h0, periph_irq});
      // unit one special event gives a period of 0x11 counts
      wr(IDX_CV1_LO, 8'h10);
      wr(IDX_T1_LO, 8'h00);
      wr(IDX_U1_CTL, {4'h0, MODE_SPECIAL});
      wr(IDX_T1_CTL, 8'h01);
      for (int i = 0; i < 8; i++) begin
         rdc(IDX_T1_HI, 8'h00, "timer high in period");
         xfer(1'b0, IDX_T1_LO, 8'h00);
         chk("period low", 16'h0001, {15'h0, rd <= 8'h10});
      end
      // trigger at the top of the count: cleared, yet no rollover flag
      wr(IDX_CV1_HI, 8'hFF);
      wr(IDX_CV1_LO, 8'hFF);
      wr(IDX_T1_HI, 8'hFF);
      wr(IDX_T1_LO, 8'hF0);
      repeat (40) @(posedge clk);
      rdc(IDX_FLAGS1, 8'h04, "no overflow flag");
      // unit two special event on external counts starts conversions
      wr(IDX_U1_CTL, CTL_CLEAR);
      wr(IDX_CV2_LO, 8'h08);
      wr(IDX_CV2_HI, 8'h00);
      conv_on <= 1'b1;
      pulse_on <= 1'b1;
      wr(IDX_U2_CTL, {4'h0, MODE_SPECIAL});
      wr(IDX_T1_CTL, 8'h03);
      wr(IDX_T1_LO, 8'h00);
      repeat (100) @(posedge clk);
      rdc(IDX_FLAGS2, 8'h01, "unit two flag");
      chk("conversion started", 16'h0001, {15'h0, n_start > 0});
      rdc(IDX_T1_HI, 8'h00, "timer cleared by unit two");
      xfer(1'b0, IDX_T1_LO, 8'h00);
      chk("unit two period", 16'h0001, {15'h0, rd <= 8'h08});
      conv_on <= 1'b0;
      tally_clr <= 1'b1;
      @(posedge clk);
      tally_clr <= 1'b0;
      repeat (100) @(posedge clk);
      chk("no start when off", 16'h0000, {15'h0, n_start > 0});
      // unit two drives its own pin high on its next match
      wr(IDX_U2_CTL, {4'h0, MODE_SET_HIGH});
      repeat (50) @(posedge clk);
      chk("unit two pin", 16'h0001, {15'h0, compare_out[1]});
      // timer two ratios 1, 4, 16 over a period of four counts
      wr(IDX_EN1, 8'h02);
      wr(IDX_T2_PER, 8'h03);
      for (int p = 0; p < 3; p++) begin
         int dv;
         dv = (p == 0) ? 1 : (p == 1) ? 4 : 16;
         wr(IDX_T2_CTL, 8'h00);
         wr(IDX_T2_CNT, 8'h00);
         wr(IDX_FLAGS1, 8'h00);
         wr(IDX_T2_CTL, {5'h00, 1'b1, 2'(p)});
         wait_sig(1'b1, 1'b1, n);
         chk("timer two ratio", 16'h0001,
             {15'h0, n >= 3 * dv && n <= 4 * dv + 6});
      end
      print_verdict();
   end
endmodule
`default_nettype wire
